// file: src/modulator_bitstream_and_gain.sv
// Behaviour
// RL1: gain codes 0..7 give 1/3,1,2,4,8,16,32,64
// RL2: above 16x analog stays 16x, rest digital
// RL3: digital gain sits after modulator, in filter path
// RL4: modulator result refreshed once per sampling clock
// RL5: bitstream mode drives pin and result register
// RL6: bitstream mode stops filter and data ready
// RL7: bitstream mode always drives the shared pin
// RL8: five levels encoded as four-bit thermometer
// RL9: four bits sent serially, msb first
// RL10: clock select 11 drives master clock out
// RL11: receiver clocks bits with master clock ratio
// RL12: bitstream idles at default zero code
// RL13: restart holds pin high two periods, then default
// RL14: four bits per sampling clock period
//
// The APB slave port is this design's own decision.
`include "mod_bits_params.svh"

module modulator_bitstream_and_gain
   import mod_bits_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int FRAC_W = 2
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic [31:0]            o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // analog front end
   input  wire logic              i_analog_master_clock,
   input  wire logic [2:0]        i_mod_level,
   output logic [2:0]             o_analog_gain,
   output logic                   o_filter_en,
   // decimation filter
   input  wire logic [15+FRAC_W:0] i_filt_data,
   input  wire logic              i_filt_valid,
   // pins
   output logic                   o_event_or_bitstream_pin,
   output logic                   o_event_or_bitstream_pin_oe,
   output logic                   o_mclk_pin,
   output logic                   o_mclk_pin_oe,
   output logic                   o_data_ready
);

   // elaboration check on the parameters
   if (ADDR_W < 4 || FRAC_W < 1 || FRAC_W > 8) begin : g_param_check
      $error("unsupported parameter values");
   end

   localparam int DW = 16 + FRAC_W;

   // thermometer encoding of a signed five-level result
   function automatic thermo_t encode_level(input logic [2:0] lvl);
      case (lvl)
         3'h2:    encode_level = 4'hF;
         3'h1:    encode_level = 4'h7;
         3'h7:    encode_level = 4'h1;
         3'h6:    encode_level = 4'h0;
         default: encode_level = 4'h3;
      endcase
   endfunction

   // shift and round the filter word, saturating to 16 bits
   function automatic logic [15:0] digital_gain(input logic [DW-1:0] d,
                                                input gain_code_t g);
      logic signed [DW+2:0] ext;
      logic signed [DW+2:0] rnd;
      ext = {{3{d[DW-1]}}, d};
      case (g)
         3'h6:    ext = ext <<< 1;
         3'h7:    ext = ext <<< 2;
         default: ext = ext;
      endcase
      rnd = (ext + (DW+3)'(1 << (FRAC_W - 1))) >>> FRAC_W;
      if (rnd > (DW+3)'(32767)) begin
         digital_gain = 16'h7FFF;
      end else if (rnd < -(DW+3)'(32768)) begin
         digital_gain = 16'h8000;
      end else begin
         digital_gain = rnd[15:0];
      end
   endfunction

   // input synchronisers
   logic       analog_master_clock_s1_r;
   logic       analog_master_clock_s2_r;
   logic       analog_master_clock_s3_r;
   logic [2:0] lvl_s1_r;
   logic [2:0] lvl_s2_r;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         analog_master_clock_s1_r <= 1'b0;
         analog_master_clock_s2_r <= 1'b0;
         analog_master_clock_s3_r <= 1'b0;
         lvl_s1_r   <= 3'h0;
         lvl_s2_r   <= 3'h0;
      end else begin
         analog_master_clock_s1_r <= i_analog_master_clock;
         analog_master_clock_s2_r <= analog_master_clock_s1_r;
         analog_master_clock_s3_r <= analog_master_clock_s2_r;
         lvl_s1_r   <= i_mod_level;
         lvl_s2_r   <= lvl_s1_r;
      end
   end

   logic analog_master_clock_tick;
   assign analog_master_clock_tick = analog_master_clock_s2_r & ~analog_master_clock_s3_r;

   // apb access and registers
   logic [8:0]  ctrl_r;
   logic [8:0]  ctrl_nxt;
   logic [15:0] result_r;
   logic [15:0] result_nxt;
   logic        ready_r;
   logic        ready_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        restart_r;
   logic        restart_nxt;

   gain_code_t    gain;
   logic [1:0]    irq_mode;
   logic [1:0]    clk_sel;
   logic          bits_mode;
   stream_state_t state_r;
   stream_state_t state_nxt;
   logic [1:0]    sync_cnt_r;
   logic [1:0]    sync_cnt_nxt;
   thermo_t       code_now;
   logic          ser_bit;
   logic          ser_load;

   assign gain      = ctrl_r[`GAIN_LSB +: 3];
   assign irq_mode  = ctrl_r[`IRQ_MODE_LSB +: 2];
   assign clk_sel   = ctrl_r[`CLK_SEL_LSB +: 2];
   assign bits_mode = irq_mode[1]; // RL5
   assign code_now  = encode_level(lvl_s2_r); // RL8

   logic acc_done;
   logic wr_ok;
   logic rd_result;
   assign acc_done  = i_psel & i_penable & pready_r;
   assign wr_ok     = acc_done & i_pwrite & (i_paddr == ADDR_W'(`REG_CONTROL));
   assign rd_result = acc_done & ~i_pwrite & (i_paddr == ADDR_W'(`REG_RESULT));

   always_comb begin
      ctrl_nxt    = ctrl_r;
      restart_nxt = 1'b0;
      pready_nxt  = i_psel & i_penable & ~pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt  = 32'h0000_0000;
      if (i_psel & i_penable & ~pready_r) begin
         case (i_paddr)
            ADDR_W'(`REG_RESULT):  prdata_nxt = {16'h0000, result_r};
            ADDR_W'(`REG_CONTROL): prdata_nxt = {23'h000000, ctrl_r};
            ADDR_W'(`REG_STATUS):  prdata_nxt = {20'h00000, ser_bit, state_r,
                                                 code_now, 3'h0, ready_r};
            default:               pslverr_nxt = 1'b1;
         endcase
         if (i_pwrite && i_paddr == ADDR_W'(`REG_STATUS)) begin
            pslverr_nxt = 1'b1;
         end
      end
      if (wr_ok) begin
         ctrl_nxt    = {1'b0, i_pwdata[7:0]};
         restart_nxt = i_pwdata[`RESTART_BIT];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r    <= `CONTROL_RST;
         restart_r <= 1'b0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         ctrl_r    <= ctrl_nxt;
         restart_r <= restart_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // result register and data ready flag
   always_comb begin
      result_nxt = result_r;
      ready_nxt  = ready_r;
      if (rd_result) begin
         ready_nxt = 1'b0;
      end
      if (bits_mode) begin
         ready_nxt = 1'b0; // RL6
         if (ser_load) begin
            result_nxt = {12'h000, code_now}; // RL4 RL5
         end
      end else if (i_filt_valid) begin
         result_nxt = digital_gain(i_filt_data, gain); // RL2 RL3
         ready_nxt  = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         result_r <= 16'h0000;
         ready_r  <= 1'b0;
      end else begin
         result_r <= result_nxt;
         ready_r  <= ready_nxt;
      end
   end

   // bitstream sequencing
   always_comb begin
      state_nxt    = state_r;
      sync_cnt_nxt = sync_cnt_r;
      case (state_r)
         ST_NORMAL: begin
            if (bits_mode) begin
               state_nxt    = ST_SYNC;
               sync_cnt_nxt = 2'h0;
            end
         end
         ST_SYNC: begin
            // count 0 holds the pin until the first tick, so both high sync periods are whole
            if (analog_master_clock_tick) begin
               if (sync_cnt_r == `SYNC_PERIODS) begin
                  state_nxt = ST_STREAM; // RL13
               end else begin
                  sync_cnt_nxt = sync_cnt_r + 2'h1; // RL13
               end
            end
         end
         ST_STREAM: begin
            if (restart_r) begin
               state_nxt    = ST_SYNC; // RL13
               sync_cnt_nxt = 2'h0;
            end
         end
         default: begin
            state_nxt    = ST_NORMAL;
            sync_cnt_nxt = 2'h0;
         end
      endcase
      if (!bits_mode) begin
         state_nxt = ST_NORMAL;
      end else if (restart_r) begin
         state_nxt    = ST_SYNC;
         sync_cnt_nxt = 2'h0;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r    <= ST_NORMAL;
         sync_cnt_r <= 2'h0;
      end else begin
         state_r    <= state_nxt;
         sync_cnt_r <= sync_cnt_nxt;
      end
   end

   thermo_serializer u_ser (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_tick     (analog_master_clock_tick),
      .i_restart  (state_r != ST_STREAM),
      .i_code     (code_now),
      .o_bit      (ser_bit),
      .o_load     (ser_load)
   );

   // output pins
   logic pin_r;
   logic pin_nxt;
   logic pin_oe_r;
   logic pin_oe_nxt;
   logic mclk_r;
   logic mclk_nxt;
   logic mclk_oe_r;
   logic mclk_oe_nxt;
   logic [2:0] again_nxt;
   logic [2:0] again_q;
   logic filt_en_r;

   always_comb begin
      case (state_r)
         ST_SYNC: begin
            pin_nxt    = (sync_cnt_r == 2'h0) ? pin_r : 1'b1; // RL13
            pin_oe_nxt = 1'b1; // RL7
         end
         ST_STREAM: begin
            pin_nxt    = ser_bit; // RL5 RL9
            pin_oe_nxt = 1'b1; // RL7
         end
         default: begin
            pin_nxt    = 1'b0;
            pin_oe_nxt = ready_nxt | bits_mode; // RL7
         end
      endcase
      mclk_oe_nxt = (clk_sel == 2'h3); // RL10
      mclk_nxt    = mclk_oe_nxt & analog_master_clock_s2_r; // RL10
      again_nxt   = (gain > 3'h5) ? 3'h5 : gain; // RL1 RL2
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_r     <= 1'b0;
         pin_oe_r  <= 1'b0;
         mclk_r    <= 1'b0;
         mclk_oe_r <= 1'b0;
         again_q   <= 3'h1;
         filt_en_r <= 1'b1;
      end else begin
         pin_r     <= pin_nxt;
         pin_oe_r  <= pin_oe_nxt;
         mclk_r    <= mclk_nxt;
         mclk_oe_r <= mclk_oe_nxt;
         again_q   <= again_nxt;
         filt_en_r <= ~bits_mode; // RL6
      end
   end

   assign o_prdata                    = prdata_r;
   assign o_pready                    = pready_r;
   assign o_pslverr                   = pslverr_r;
   assign o_analog_gain               = again_q;
   assign o_filter_en                 = filt_en_r;
   assign o_event_or_bitstream_pin    = pin_r;
   assign o_event_or_bitstream_pin_oe = pin_oe_r;
   assign o_mclk_pin                  = mclk_r;
   assign o_mclk_pin_oe               = mclk_oe_r;
   assign o_data_ready                = ready_r;

endmodule

// file: src/mod_bits_params.svh
`ifndef MOD_BITS_PARAMS_SVH
`define MOD_BITS_PARAMS_SVH

// register byte offsets
`define REG_RESULT       12'h000
`define REG_CONTROL      12'h004
`define REG_STATUS       12'h008

// control field positions
`define GAIN_LSB         0
`define IRQ_MODE_LSB     4
`define CLK_SEL_LSB      6
`define RESTART_BIT      8

// reset values
`define CONTROL_RST      9'h001
`define DEFAULT_CODE     4'h3

// timing counts, in analog master clock periods
`define SYNC_PERIODS     2'h2
`define BITS_PER_SAMPLE  3'h4

`endif

// file: src/mod_bits_pkg.sv
package mod_bits_pkg;

   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_SYNC   = 3'b010,
      ST_STREAM = 3'b100
   } stream_state_t;

   typedef logic [2:0] gain_code_t;
   typedef logic [3:0] thermo_t;

endpackage

// file: src/thermo_serializer.sv
`include "mod_bits_params.svh"

module thermo_serializer
   import mod_bits_pkg::*;
(
   // clock and reset
   input  wire logic    i_core_clk,
   input  wire logic    i_rst,
   // control
   input  wire logic    i_tick,
   input  wire logic    i_restart,
   input  wire thermo_t i_code,
   // serial side
   output logic         o_bit,
   output logic         o_load
);

   thermo_t    cur_r;
   thermo_t    cur_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;

   always_comb begin
      cur_nxt = cur_r;
      cnt_nxt = cnt_r;
      o_load  = 1'b0;
      if (i_restart) begin
         cur_nxt = `DEFAULT_CODE; // RL13
         cnt_nxt = 2'h0;
      end else if (i_tick) begin
         cnt_nxt = cnt_r + 2'h1; // RL9
         if (cnt_r == 2'(`BITS_PER_SAMPLE - 3'h1)) begin
            cur_nxt = i_code; // RL14
            o_load  = 1'b1;
         end
      end
   end

   // msb first, so the pattern on the wire equals the comparator code
   assign o_bit = cur_r[2'h3 - cnt_r]; // RL9

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cur_r <= `DEFAULT_CODE; // RL12
         cnt_r <= 2'h0;
      end else begin
         cur_r <= cur_nxt;
         cnt_r <= cnt_nxt;
      end
   end

endmodule

// file: sim/mod_bits_props.sv
`include "mod_bits_params.svh"

module mod_bits_props #(
   parameter int ADDR_W = 12,
   parameter int FRAC_W = 2
) (
   input wire logic              i_core_clk,
   input wire logic              i_rst,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic              i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0]       i_pwdata,
   input wire logic              o_pready,
   input wire logic              i_analog_master_clock,
   input wire logic [2:0]        o_analog_gain,
   input wire logic              o_filter_en,
   input wire logic              i_filt_valid,
   input wire logic              o_event_or_bitstream_pin,
   input wire logic              o_event_or_bitstream_pin_oe,
   input wire logic              o_mclk_pin,
   input wire logic              o_mclk_pin_oe,
   input wire logic              o_data_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_ctl_wr;
      i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_W'(`REG_CONTROL);
   endsequence
   sequence s_sync_high;
      (o_event_or_bitstream_pin && o_event_or_bitstream_pin_oe) [*8];
   endsequence
   property p_gain_low;
      s_ctl_wr ##0 i_pwdata[2:0] < 3'h6 |=> ##1 o_analog_gain == $past(i_pwdata[2:0], 2);
   endproperty
   a_gain_low: assert property (p_gain_low) else $error("gain");
   property p_gain_high;
      s_ctl_wr ##0 i_pwdata[2:0] > 3'h5 |=> ##1 o_analog_gain == 3'h5;
   endproperty
   a_gain_high: assert property (p_gain_high) else $error("gain high");
   property p_mode_on;
      s_ctl_wr ##0 i_pwdata[5] |-> ##[1:3] !o_filter_en && o_event_or_bitstream_pin_oe;
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("mode entry");
   property p_drive;
      !o_filter_en && !$past(o_filter_en, 3) |-> o_event_or_bitstream_pin_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("pin released");
   property p_no_ready;
      !o_filter_en && !$past(o_filter_en, 2) |-> !o_data_ready;
   endproperty
   a_no_ready: assert property (p_no_ready) else $error("ready in mode");
   property p_ready;
      i_filt_valid && o_filter_en |-> ##[1:2] o_data_ready
         ##[1:2] (o_event_or_bitstream_pin_oe && !o_event_or_bitstream_pin);
   endproperty
   a_ready: assert property (p_ready) else $error("ready");
   property p_mclk;
      o_mclk_pin_oe && $rose(i_analog_master_clock) |-> ##[1:5] o_mclk_pin;
   endproperty
   a_mclk: assert property (p_mclk) else $error("mclk");
   property p_restart;
      s_ctl_wr ##0 (i_pwdata[8] && i_pwdata[5]) |-> ##[1:16] s_sync_high;
   endproperty
   a_restart: assert property (p_restart) else $error("sync");
endmodule

bind modulator_bitstream_and_gain mod_bits_props #(
   .ADDR_W (ADDR_W),
   .FRAC_W (FRAC_W)
) u_props (
   .i_core_clk                  (i_core_clk),
   .i_rst                       (i_rst),
   .i_psel                      (i_psel),
   .i_penable                   (i_penable),
   .i_pwrite                    (i_pwrite),
   .i_paddr                     (i_paddr),
   .i_pwdata                    (i_pwdata),
   .o_pready                    (o_pready),
   .i_analog_master_clock       (i_analog_master_clock),
   .o_analog_gain               (o_analog_gain),
   .o_filter_en                 (o_filter_en),
   .i_filt_valid                (i_filt_valid),
   .o_event_or_bitstream_pin    (o_event_or_bitstream_pin),
   .o_event_or_bitstream_pin_oe (o_event_or_bitstream_pin_oe),
   .o_mclk_pin                  (o_mclk_pin),
   .o_mclk_pin_oe               (o_mclk_pin_oe),
   .o_data_ready                (o_data_ready)
);

// file: sim/stream_receiver.sv
module stream_receiver (
   // link side
   input  wire logic   i_analog_master_clock,
   input  wire logic   i_pin,
   // collected bits
   output logic [31:0] o_shift
);
   timeunit 1ns;
   timeprecision 1ps;
   // each bit is taken on the following rising analog clock edge
   always_ff @(posedge i_analog_master_clock) begin
      o_shift <= {o_shift[30:0], i_pin};
   end
endmodule

// file: sim/testbench.sv
`include "mod_bits_params.svh"

module testbench
   import mod_bits_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk = 0;
   logic        i_rst = 1;
   logic        i_psel = 0;
   logic        i_penable = 0;
   logic        i_pwrite = 0;
   logic [11:0] i_paddr = 0;
   logic [31:0] i_pwdata = 0;
   logic        i_analog_master_clock = 0;
   logic [2:0]  i_mod_level = 0;
   logic [17:0] i_filt_data = 0;
   logic        i_filt_valid = 0;
   logic [31:0] o_prdata, rd, rx_bits;
   logic [2:0]  o_analog_gain;
   logic        o_pready, o_pslverr, o_filter_en, o_data_ready, err, o_mclk_pin, o_mclk_pin_oe;
   logic        o_event_or_bitstream_pin, o_event_or_bitstream_pin_oe;
   logic [17:0] fd;
   thermo_t     th;
   int          fail_count = 0;
   int          checked = 0;
   int          exp;
   always #2.5 i_core_clk = ~i_core_clk;
   always #24 i_analog_master_clock = ~i_analog_master_clock;
   modulator_bitstream_and_gain #(.ADDR_W(12), .FRAC_W(2)) dut (
      .i_core_clk                  (i_core_clk),
      .i_rst                       (i_rst),
      .i_psel                      (i_psel),
      .i_penable                   (i_penable),
      .i_pwrite                    (i_pwrite),
      .i_paddr                     (i_paddr),
      .i_pwdata                    (i_pwdata),
      .o_prdata                    (o_prdata),
      .o_pready                    (o_pready),
      .o_pslverr                   (o_pslverr),
      .i_analog_master_clock       (i_analog_master_clock),
      .i_mod_level                 (i_mod_level),
      .o_analog_gain               (o_analog_gain),
      .o_filter_en                 (o_filter_en),
      .i_filt_data                 (i_filt_data),
      .i_filt_valid                (i_filt_valid),
      .o_event_or_bitstream_pin    (o_event_or_bitstream_pin),
      .o_event_or_bitstream_pin_oe (o_event_or_bitstream_pin_oe),
      .o_mclk_pin                  (o_mclk_pin),
      .o_mclk_pin_oe               (o_mclk_pin_oe),
      .o_data_ready                (o_data_ready)
   );
   stream_receiver rx (.i_analog_master_clock(i_analog_master_clock),
      .i_pin(o_event_or_bitstream_pin), .o_shift(rx_bits));
   function automatic thermo_t thermo(int l);
      return thermo_t'((1 << (l + 2)) - 1);
   endfunction
   task automatic give_verdict;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] want, logic [31:0] got);
      checked++;
      if (got !== want) begin
         fail_count++;
         $display("FAIL %s exp %h got %h", what, want, got);
      end
   endtask
   task automatic chk_stream(string what, logic [31:0] hay, logic [31:0] pat, int n);
      logic [31:0] m;
      bit          hit;
      m = (32'h1 << n) - 1;
      hit = 0;
      for (int i = 0; i <= 32 - n; i++) begin
         if (((hay >> i) & m) === (pat & m)) hit = 1;
      end
      chk(what, 1, hit);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge i_core_clk);
      i_psel <= 1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1;
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
      if (n >= 20) begin
         fail_count++;
         give_verdict();
      end
   endtask
   task automatic filt_pulse(input logic [17:0] d);
      @(posedge i_core_clk);
      i_filt_data <= d;
      i_filt_valid <= 1;
      @(posedge i_core_clk);
      i_filt_valid <= 0;
      repeat (3) @(posedge i_core_clk);
   endtask
   initial begin
      rd = $urandom(17819);
      repeat (2) @(posedge i_core_clk);
      i_rst <= 0;
      apb(0, 12'h004, 0);
      chk("control", 32'h1, rd);
      apb(0, 12'h008, 0);
      chk("status", {21'h0, ST_NORMAL, `DEFAULT_CODE, 4'h0}, rd & 32'h7FF);
      for (int g = 0; g < 8; g++) begin
         apb(1, 12'h004, g);
         apb(0, 12'h004, 0);
         chk("gain", (g > 5) ? 5 : g, o_analog_gain);
         fd = (g == 7) ? 18'h1FFFF : 18'($urandom);
         filt_pulse(fd);
         exp = $signed(fd) * ((g == 6) ? 2 : (g == 7) ? 4 : 1);
         exp = (exp + 2) >>> 2;
         exp = (exp > 32767) ? 32767 : (exp < -32768) ? -32768 : exp;
         chk("event", 3'b110, {o_data_ready, o_event_or_bitstream_pin_oe,
            o_event_or_bitstream_pin});
         apb(0, 12'h000, 0);
         chk("result", {16'h0, 16'(exp)}, rd);
      end
      apb(0, 12'h00C, 0);
      chk("unmapped", 1, err);
      chk("unmapped data", 0, rd);
      apb(1, 12'h008, 32'hF);
      chk("status wr", 1, err);
      for (int s = 0; s < 4; s++) begin
         apb(1, 12'h004, 32'(s << 6) | 32'h1);
         repeat (12) @(posedge i_core_clk);
         chk("mclk oe", s == 3, o_mclk_pin_oe);
         @(posedge i_analog_master_clock);
         repeat (4) @(posedge i_core_clk);
         chk("mclk high", s == 3, o_mclk_pin);
         @(negedge i_analog_master_clock);
         repeat (4) @(posedge i_core_clk);
         chk("mclk low", 0, o_mclk_pin);
      end
      i_mod_level <= 3'h6;
      for (int r = 0; r < 2; r++) begin
         apb(1, 12'h004, r ? 32'h121 : 32'h021);
         repeat (22) @(posedge i_analog_master_clock);
         @(posedge i_core_clk);
         th = thermo(-2);
         chk_stream("restart", rx_bits, {1'b0, 2'b11, `DEFAULT_CODE, th, th}, 15);
      end
      filt_pulse(18'h00100);
      chk("mode", 3'b010, {o_filter_en, o_event_or_bitstream_pin_oe, o_data_ready});
      for (int l = -2; l < 3; l++) begin
         i_mod_level <= 3'(l);
         repeat (18) @(posedge i_analog_master_clock);
         @(posedge i_core_clk);
         th = thermo(l);
         chk_stream("bits", {8{th}}, rx_bits, 12);
         apb(0, 12'h000, 0);
         chk("stream result", {28'h0, th}, rd);
      end
      give_verdict();
   end
endmodule
